// [core/sledi_consts.vh]
// Constants for the status LED indicator block
`ifndef SLEDI_CONSTS_VH
`define SLEDI_CONSTS_VH

// Register byte offsets
`define SLEDI_OFF_CTRL 12'h000
`define SLEDI_OFF_STATUS 12'h004
`define SLEDI_OFF_IRQ_STAT 12'h008
`define SLEDI_OFF_IRQ_MASK 12'h00C
`define SLEDI_OFF_OVR_LEDS 12'h010

// Control register fields
`define SLEDI_CTRL_CONFIGURED 0
`define SLEDI_CTRL_CFG_FAULT 1
`define SLEDI_CTRL_LOW_SUPPLY 2
`define SLEDI_CTRL_FW_UPDATE 3
`define SLEDI_CTRL_RUNNING 4
`define SLEDI_CTRL_SCRIPT_EN 5
`define SLEDI_CTRL_RESET 32'h0000_0000

// Interrupt event bits
`define SLEDI_EV_TRAFFIC 0
`define SLEDI_EV_ERRFRAME 1
`define SLEDI_EV_OVERRUN 2
`define SLEDI_EV_BUSOFF 3
`define SLEDI_EV_PASSIVE 4
`define SLEDI_EV_W 5

// Timing, in microseconds, at a 20 ns clock
`define SLEDI_CLK_NS 20
`define SLEDI_SLOW_HALF_US 500000
`define SLEDI_FAST_HALF_US 125000
`define SLEDI_FLASH_US 20000
`define SLEDI_RUN_STEP_US 250000

`endif

// [core/sledi_top.v]
// Status LED indicator with APB register slave
// What this block does
// - When configured and healthy the power LED is steady green.
// - Before configuration the power LED slow-blinks yellow and traffic stays off.
// - A firmware configuration fault slow-wavers power green/yellow and traffic yellow/red.
// - A low-supply fault slow-wavers power green/yellow and slow-blinks traffic yellow.
// - An idle channel leaves the traffic LED off.
// - Each CAN message gives a short yellow flash, each error frame a short red flash.
// - An error-passive channel fast-blinks traffic red.
// - An overrun holds traffic steady red until bus-off clears it.
// - During firmware update all traffic LEDs fast-blink yellow.
// - Slow blink has equal lit and unlit phases, repeating.
// - Fast blink has equal phases at a higher rate than slow blink.
// - Waver shows the second colour in place of the unlit phase.
// - A flash lights briefly per event and back-to-back events merge.
// - Running lights one colour at a time: power green, power yellow, traffic yellow, red.
// - Errors drive the red element of all traffic LEDs together.
// - A script may override any LED, with no default script indication.
`timescale 1ns/100ps
`default_nettype none
`include "sledi_consts.vh"

module sledi_top #(
	parameter SLOW_HALF = `SLEDI_SLOW_HALF_US * 1000 / `SLEDI_CLK_NS,
	parameter FAST_HALF = `SLEDI_FAST_HALF_US * 1000 / `SLEDI_CLK_NS,
	parameter FLASH_LEN = `SLEDI_FLASH_US * 1000 / `SLEDI_CLK_NS,
	parameter RUN_STEP = `SLEDI_RUN_STEP_US * 1000 / `SLEDI_CLK_NS
)(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire can_msg_event,
	input wire can_err_frame,
	input wire can_err_passive,
	input wire can_overrun,
	input wire can_bus_off,
	output reg power_indicator_label_green,
	output reg power_indicator_label_yellow,
	output reg traffic_yellow,
	output reg traffic_red,
	output reg irq
);

	// ----------------------------------------
	// Registers and bus
	// ----------------------------------------
	reg [5:0] ctrl;
	reg [`SLEDI_EV_W-1:0] irq_stat;
	reg [`SLEDI_EV_W-1:0] irq_mask;
	reg [3:0] ovr_leds;
	reg overrun_hold;
	reg [1:0] run_idx;
	wire flash_y_on;
	wire flash_r_on;
	wire wr = psel & penable & pwrite;
	wire rd_setup = psel & ~penable;
	wire mapped = (paddr == `SLEDI_OFF_CTRL) | (paddr == `SLEDI_OFF_STATUS) |
		(paddr == `SLEDI_OFF_IRQ_STAT) | (paddr == `SLEDI_OFF_IRQ_MASK) |
		(paddr == `SLEDI_OFF_OVR_LEDS);
	wire [`SLEDI_EV_W-1:0] ev;
	reg [31:0] next_rdata;

	assign ev = {can_err_passive, can_bus_off, can_overrun, can_err_frame, can_msg_event};

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always @*
	begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			`SLEDI_OFF_CTRL: next_rdata = {26'h000_0000, ctrl};
			`SLEDI_OFF_STATUS: next_rdata = {24'h00_0000, run_idx, flash_r_on, flash_y_on,
				overrun_hold, can_err_passive, can_bus_off, 1'b0};
			`SLEDI_OFF_IRQ_STAT: next_rdata = {27'h000_0000, irq_stat};
			`SLEDI_OFF_IRQ_MASK: next_rdata = {27'h000_0000, irq_mask};
			`SLEDI_OFF_OVR_LEDS: next_rdata = {28'h000_0000, ovr_leds};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// No wait state: answer in the cycle after the setup phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= rd_setup;
			pslverr <= rd_setup & ~mapped;
			prdata <= (rd_setup & ~pwrite) ? next_rdata : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Write path
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= 6'h00;
			irq_mask <= 5'h00;
			ovr_leds <= 4'h0;
		end
		else if (wr & pready)
		begin
			if (paddr == `SLEDI_OFF_CTRL)
				ctrl <= pwdata[5:0];
			if (paddr == `SLEDI_OFF_IRQ_MASK)
				irq_mask <= pwdata[4:0];
			if (paddr == `SLEDI_OFF_OVR_LEDS)
				ovr_leds <= pwdata[3:0];
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	// Set wins over write-one-to-clear so no event is lost
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat <= 5'h00;
		end
		else if (wr & pready & (paddr == `SLEDI_OFF_IRQ_STAT))
		begin
			irq_stat <= (irq_stat & ~pwdata[4:0]) | ev;
		end
		else
		begin
			irq_stat <= irq_stat | ev;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------
	// Pattern generators
	// ----------------------------------------
	reg [31:0] run_cnt;
	wire [1:0] blink_ph;
	wire [1:0] flash_on;
	wire [1:0] flash_hit;
	wire slow_ph;
	wire fast_ph;
	genvar g;

	assign flash_hit = {can_err_frame, can_msg_event};
	assign slow_ph = blink_ph[0];
	assign fast_ph = blink_ph[1];
	assign flash_y_on = flash_on[0];
	assign flash_r_on = flash_on[1];

	// Entry 0 is slow blink, entry 1 fast blink; equal phases in both
	// Fast differs only by its shorter half period, so both share one structure
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_blink
			localparam [31:0] HALF = (g == 0) ? SLOW_HALF : FAST_HALF;
			reg [31:0] cnt;
			reg ph;

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cnt <= 32'h0000_0000;
					ph <= 1'b0;
				end
				else if (cnt >= HALF - 32'h0000_0001)
				begin
					cnt <= 32'h0000_0000;
					ph <= ~ph;
				end
				else
				begin
					cnt <= cnt + 32'h0000_0001;
				end
			end

			assign blink_ph[g] = ph;
		end
	endgenerate

	// ----------------------------------------
	// Running sequence
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_cnt <= 32'h0000_0000;
			run_idx <= 2'b00;
		end
		else if (!ctrl[`SLEDI_CTRL_RUNNING])
		begin
			// Parked on the first step so the sequence always opens on power green
			run_cnt <= 32'h0000_0000;
			run_idx <= 2'b00;
		end
		else if (run_cnt >= RUN_STEP - 1)
		begin
			run_cnt <= 32'h0000_0000;
			run_idx <= run_idx + 2'b01;
		end
		else
		begin
			run_cnt <= run_cnt + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// Flash stretchers
	// ----------------------------------------
	// Entry 0 yellow for messages, entry 1 red for error frames
	// Each event restarts the window, so a burst merges into steady light
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_flash
			reg [31:0] cnt;
			reg on;

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cnt <= 32'h0000_0000;
					on <= 1'b0;
				end
				else if (flash_hit[g])
				begin
					cnt <= FLASH_LEN - 1;
					on <= 1'b1;
				end
				else if (cnt != 32'h0000_0000)
				begin
					cnt <= cnt - 32'h0000_0001;
				end
				else
				begin
					on <= 1'b0;
				end
			end

			assign flash_on[g] = on;
		end
	endgenerate

	// ----------------------------------------
	// Overrun latch
	// ----------------------------------------
	// Only bus-off releases it; when both arrive together the release wins
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			overrun_hold <= 1'b0;
		end
		else if (can_bus_off)
		begin
			overrun_hold <= 1'b0;
		end
		else if (can_overrun)
		begin
			overrun_hold <= 1'b1;
		end
	end

	// ----------------------------------------
	// Indication priority
	// ----------------------------------------
	reg next_pg;
	reg next_py;
	reg next_ty;
	reg next_tr;

	always @*
	begin
		next_pg = 1'b0;
		next_py = 1'b0;
		next_ty = 1'b0;
		next_tr = 1'b0;
		if (ctrl[`SLEDI_CTRL_SCRIPT_EN])
		begin
			{next_pg, next_py, next_ty, next_tr} = ovr_leds;
		end
		else if (ctrl[`SLEDI_CTRL_RUNNING])
		begin
			next_pg = (run_idx == 2'd0);
			next_py = (run_idx == 2'd1);
			next_ty = (run_idx == 2'd2);
			next_tr = (run_idx == 2'd3);
		end
		else if (ctrl[`SLEDI_CTRL_CFG_FAULT])
		begin
			next_pg = slow_ph;
			next_py = ~slow_ph;
			next_ty = slow_ph;
			next_tr = ~slow_ph;
		end
		else if (ctrl[`SLEDI_CTRL_LOW_SUPPLY])
		begin
			next_pg = slow_ph;
			next_py = ~slow_ph;
			next_ty = slow_ph;
		end
		else if (!ctrl[`SLEDI_CTRL_CONFIGURED])
		begin
			next_py = slow_ph;
		end
		else
		begin
			next_pg = 1'b1;
			// Faults outrank flashes
			if (ctrl[`SLEDI_CTRL_FW_UPDATE])
				next_ty = fast_ph;
			else if (overrun_hold)
				next_tr = 1'b1;
			else if (can_err_passive)
				next_tr = fast_ph;
			else
			begin
				next_ty = flash_y_on;
				next_tr = flash_r_on;
			end
		end
	end

	// ----------------------------------------
	// LED output registers
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			power_indicator_label_green <= 1'b0;
			power_indicator_label_yellow <= 1'b0;
			traffic_yellow <= 1'b0;
			traffic_red <= 1'b0;
		end
		else
		begin
			power_indicator_label_green <= next_pg;
			power_indicator_label_yellow <= next_py;
			traffic_yellow <= next_ty;
			traffic_red <= next_tr;
		end
	end

endmodule
`default_nettype wire

// [testbench/sledi_led_model.sv]
// Run-length monitor for one LED element
`timescale 1ns/100ps
`default_nettype none
module sledi_led_model (
	input wire logic pclk,
	input wire logic a,
	output logic [31:0] hi_len,
	output logic [31:0] lo_len
);
logic [31:0] run = 0;
logic last = 0;
// -----------------------------
// Lit and unlit phase lengths
// -----------------------------
always @(posedge pclk)
begin
	run <= (a == last) ? run + 1 : 32'h0000_0001;
	last <= a;
	if (a != last && last) hi_len <= run;
	if (a != last && !last) lo_len <= run;
end
endmodule
`default_nettype wire

// [testbench/sledi_top_asserts.sv]
// Port assertions for the status LED indicator
`timescale 1ns/100ps
`default_nettype none
module sledi_top_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic can_msg_event,
	input wire logic can_err_frame,
	input wire logic can_err_passive,
	input wire logic power_indicator_label_green,
	input wire logic power_indicator_label_yellow,
	input wire logic traffic_yellow,
	input wire logic traffic_red,
	input wire logic irq
);
// Green-only power and no error-passive; overrun hold or firmware update can still outrank the traffic display
wire calm = power_indicator_label_green && !power_indicator_label_yellow && !can_err_passive;
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
sequence s_setup; psel && !penable; endsequence
sequence s_done; pready ##1 !pready; endsequence
a_setup_ready: assert property (s_setup |=> s_done) else $error("ready not one cycle");
a_bad_addr: assert property (pready && paddr > 12'h010 |-> pslverr && prdata == 0)
	else $error("unmapped access not refused");
a_good_addr: assert property (pready && paddr <= 12'h010 |-> !pslverr) else $error("bad refusal");
a_stat_rsvd: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[31:8] == 0)
	else $error("reserved bits set");
a_reset_dark: assert property ($rose(presetn) |-> !(irq || traffic_red || traffic_yellow))
	else $error("outputs lit after reset");
a_msg_flash: assert property (can_msg_event && calm && !traffic_red |-> ##2 traffic_yellow[*4])
	else $error("message flash wrong");
a_err_flash: assert property (can_err_frame && calm |-> ##2 traffic_red)
	else $error("error flash missing");
a_pass_red: assert property ($rose(can_err_passive) && $past(calm) && !traffic_red |-> ##[1:4] traffic_red)
	else $error("passive red missing");
endmodule
bind sledi_top sledi_top_asserts i_sledi_top_asserts (.*);
`default_nettype wire

// [testbench/sledi_top_tb.sv]
// Self-checking testbench for the status LED indicator
`timescale 1ns/100ps
`default_nettype none
module sledi_top_tb;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
logic mev = 0, erf = 0, pas = 0, ovr = 0, bof = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, r, seed = 32'h0000_4501;
logic [31:0] expq[$];
wire [31:0] prdata, py_h, py_l, ty_h, ty_l, tr_h, tr_l;
wire pready, pslverr, pg, py, ty, tr, irq;
int fail_count = 0, checks = 0;
sledi_top #(.SLOW_HALF(8), .FAST_HALF(2), .FLASH_LEN(4), .RUN_STEP(4)) i_sledi_top (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.can_msg_event(mev), .can_err_frame(erf), .can_err_passive(pas), .can_overrun(ovr),
	.can_bus_off(bof), .power_indicator_label_green(pg), .power_indicator_label_yellow(py),
	.traffic_yellow(ty), .traffic_red(tr), .irq(irq));
sledi_led_model i_m_py (.pclk(pclk), .a(py), .hi_len(py_h), .lo_len(py_l));
sledi_led_model i_m_ty (.pclk(pclk), .a(ty), .hi_len(ty_h), .lo_len(ty_l));
sledi_led_model i_m_tr (.pclk(pclk), .a(tr), .hi_len(tr_h), .lo_len(tr_l));
initial forever #10 pclk = ~pclk;
// ----------------
// Shared tasks
// ----------------
task close_out;
	if (fail_count == 0 && checks > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
task automatic cmp(input [31:0] g, input [31:0] e);
	checks++;
	if (g !== e)
	begin
		fail_count++;
		$display("ERROR %0t got %h exp %h", $time, g, e);
	end
endtask
task automatic apb(input w, input [11:0] a, input [31:0] d, input [31:0] e);
	@(posedge pclk);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	if (!w) expq.push_back(e);
	@(posedge pclk);
	penable <= 1;
	do @(posedge pclk); while (pready !== 1'b1);
	psel <= 0;
	penable <= 0;
endtask
task automatic wait_n(input int n);
	repeat (n) @(posedge pclk);
endtask
// Read data is judged by a monitor, in issue order
always @(posedge pclk)
	if (psel && penable && pready === 1'b1 && !pwrite) cmp(prdata, expq.pop_front());
initial
begin
	#100000;
	fail_count++;
	close_out();
end
// ----------------
// Scenarios
// ----------------
initial
begin
	wait_n(20);
	presetn <= 1;
	for (int i = 0; i < 6; i++) apb(0, 12'(i * 4), 0, 0);
	wait_n(40);
	cmp(py_h, 8);
	cmp(py_l, 8);
	cmp(32'({ty, tr}), 0);
	apb(1, 12'h000, 1, 0);
	wait_n(4);
	cmp(32'({pg, py, ty, tr}), 8);
	for (int k = 0; k < 2; k++)
	begin
		{mev, erf} <= k ? 2'b01 : 2'b10;
		wait_n(1);
		{mev, erf} <= 2'b00;
		wait_n(8 + ($random(seed) & 7));
	end
	cmp(ty_h, 4);
	cmp(tr_h, 4);
	cmp(32'(irq), 0);
	apb(0, 12'h008, 0, 3);
	apb(1, 12'h00c, 32'h0000_001f, 0);
	wait_n(2);
	cmp(32'(irq), 1);
	apb(1, 12'h008, 3, 0);
	wait_n(2);
	cmp(32'(irq), 0);
	pas <= 1;
	wait_n(20);
	cmp(tr_h, 2);
	cmp(tr_l, 2);
	{pas, ovr} <= 2'b01;
	wait_n(1);
	ovr <= 0;
	wait_n(20);
	cmp(32'(tr), 1);
	bof <= 1;
	wait_n(1);
	bof <= 0;
	wait_n(4);
	cmp(32'(tr), 0);
	apb(1, 12'h000, 9, 0);
	wait_n(20);
	cmp(ty_h, 2);
	apb(1, 12'h000, 3, 0);
	wait_n(40);
	cmp(py_h, 8);
	cmp(32'({pg ^ py, ty ^ tr}), 3);
	apb(1, 12'h000, 5, 0);
	wait_n(40);
	cmp(32'({ty_h[7:0], ty_l[7:0], 7'h00, tr}), 32'h0008_0800);
	apb(1, 12'h000, 32'h0000_0011, 0);
	for (int i = 0; i < 20 && !pg; i++) wait_n(1);
	for (int i = 0; i < 4; i++)
	begin
		cmp(32'({pg, py, ty, tr}), 8 >> i);
		wait_n(4);
	end
	r = $random(seed);
	apb(1, 12'h010, r, 0);
	apb(1, 12'h000, 32'h0000_0023, 0);
	wait_n(3);
	cmp(32'({pg, py, ty, tr}), r & 15);
	apb(0, 12'h010, 0, r & 15);
	close_out();
end
endmodule
`default_nettype wire
